// ### common/arc_pkg.sv
// shared constants and types for the converter result/trigger register block
// assumes a plain byte-wide register port and one system clock
package arc_pkg;
  localparam int          RES_W         = 10;
  localparam logic [7:0]  OFS_PINDIS    = 8'h01;
  localparam logic [7:0]  OFS_RESLO     = 8'h04;
  localparam logic [7:0]  OFS_RESHI     = 8'h05;
  localparam logic [7:0]  OFS_CTLB      = 8'h03;
  localparam logic [7:0]  OFS_CTLA      = 8'h06;
  localparam logic [7:0]  OFS_IRQSTAT   = 8'h08;
  localparam logic [7:0]  OFS_IRQMASK   = 8'h09;
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam int          CB_BIPOLAR    = 7;
  localparam int          CB_CMPMUX     = 6;
  localparam int          CB_LEFTADJ    = 4;
  localparam int          CB_SPARE      = 3;
  localparam int          CA_ENABLE     = 1;
  localparam int          CA_AUTOTRIG   = 0;
  localparam int          IRQ_DONE      = 0;
  localparam int          IRQ_TRIG      = 1;
  localparam int          IRQ_DROP      = 2;
  localparam logic [9:0]  RES_SAT       = 10'h3FF;
  localparam logic [9:0]  RES_ZERO      = 10'h000;
  localparam logic [2:0]  TRIG_FREE     = 3'h0;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } arc_bus_req_t;

  typedef struct packed {
    logic       valid;
    logic       negative;
    logic [9:0] magnitude;
  } arc_sample_t;

  typedef enum logic [2:0] {
    ST_UNLOCKED = 3'b001,
    ST_LOCKED   = 3'b010,
    ST_RELEASE  = 3'b100
  } arc_lock_t;
endpackage

// ### verilog/arc_result_trigger.sv
// converter result bytes, control register b, pin input disable, trigger
// assumes: sample arrives from the analog core on clk with a valid pulse;
// trigger flags and pin levels come from outside and are synchronised here
//
// What this block does
// - each conversion finishing while the result is not frozen loads the 10-bit result into the byte pair
// - reading the low byte freezes the result until the high byte is read
// - left adjust: bits 9..2 high, bits 1..0 at low 7..6, rest zero
// - right adjust default: bits 7..0 low, bits 9..8 at high 1..0
// - left adjust is control b bit 4 and acts on readback at once
// - control b bit 7 picks bipolar; unipolar saturates negative input
// - bipolar gives two's complement 9 bits plus sign; unipolar 10 bits
// - control b bit 3 stores and returns what was written
// - trigger field bits 2:0 act only while auto trigger is on
// - auto trigger starts conversion on rising edge of the chosen flag
// - switching from a clear flag to a set flag counts as an edge
// - choosing free running never makes a trigger event itself
// - field codes: free, comparator, ext0, t0 cmpA, t0 ovf, t1 B/ovf/cap
// - a set disable bit gates the pin buffer and reads the port bit zero
// - done flag sets when a conversion finishes and the result updates
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
module arc_result_trigger
  import arc_pkg::*;
#(
  parameter int NPINS = 8
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [7:0]        regAddr,
  input  wire logic [7:0]        regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [7:0]        regRdata,
  input  wire logic              sampleValid,
  input  wire logic              sampleNegative,
  input  wire logic [RES_W-1:0]  sampleMagnitude,
  input  wire logic [7:1]        trigFlags,
  input  wire logic [NPINS-1:0]  pinLevel,
  output logic [NPINS-1:0]       pinBufferOff,
  output logic [NPINS-1:0]       portInput,
  output logic                   convStart,
  output logic                   irq
);
  // the disable register and the port view are one byte wide
  if (NPINS != 8) begin : g_npins_check
    $error("pin disable register is one byte wide");
  end

  localparam int CA_DONE = 4;

  arc_bus_req_t busReq;
  arc_sample_t  smp;
  assign busReq = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};
  assign smp    = '{valid: sampleValid, negative: sampleNegative,
                    magnitude: sampleMagnitude};

  logic [7:0]       ctlB_r;
  logic [7:0]       ctlA_r;
  logic [7:0]       pinDis_r;
  logic [RES_W-1:0] result_r;
  logic [7:0]       irqStat_r;
  logic [7:0]       irqMask_r;
  logic             doneFlag_r;
  logic             trigLevel_r;
  logic             donePrev_r;
  arc_lock_t        lock_r;
  arc_lock_t        lock_nxt;
  logic [7:1]       flagMeta_r;
  logic [7:1]       flagSync_r;
  logic [NPINS-1:0] pinMeta_r;
  logic [NPINS-1:0] pinSync_r;

  // address decode
  wire wrCtlB    = busReq.wr && busReq.addr == OFS_CTLB;
  wire wrCtlA    = busReq.wr && busReq.addr == OFS_CTLA;
  wire wrPinDis  = busReq.wr && busReq.addr == OFS_PINDIS;
  wire wrMask    = busReq.wr && busReq.addr == OFS_IRQMASK;
  wire rdLow     = busReq.rd && busReq.addr == OFS_RESLO;
  wire rdHigh    = busReq.rd && busReq.addr == OFS_RESHI;
  wire rdStat    = busReq.rd && busReq.addr == OFS_IRQSTAT;
  // done flag is cleared by writing one to it in control a
  wire clrDone   = wrCtlA && busReq.wdata[CA_DONE];

  wire leftAdj   = ctlB_r[CB_LEFTADJ];
  wire bipolar   = ctlB_r[CB_BIPOLAR];
  wire autoOn    = ctlA_r[CA_AUTOTRIG];
  wire convOn    = ctlA_r[CA_ENABLE];
  wire [2:0] trigSel = ctlB_r[2:0];

  function automatic logic [RES_W-1:0] code_of(input arc_sample_t s,
                                               input logic bip);
    logic [RES_W-1:0] m;
    m = RES_ZERO;
    if (bip) begin
      // 9 magnitude bits plus sign, two's complement
      m = {1'b0, s.magnitude[RES_W-2:0]};
      if (s.negative)
        m = RES_ZERO - m;
    end else if (s.negative) begin
      m = RES_SAT;
    end else begin
      m = s.magnitude;
    end
    return m;
  endfunction

  // left adjust works from the stored word so a flip shows immediately
  wire [7:0] resLowView  = leftAdj ? {result_r[1:0], 6'h00}
                                   : result_r[7:0];
  wire [7:0] resHighView = leftAdj ? result_r[9:2]
                                   : {6'h00, result_r[9:8]};

  // trigger mux: free running (code 0) uses the done flag as its source
  wire [7:0] flagVec = {flagSync_r, doneFlag_r};
  wire selFlag   = flagVec[trigSel];
  // free running selection never produces an edge on its own
  wire trigNow   = autoOn && (trigSel != TRIG_FREE) && selFlag;
  wire trigEdge  = trigNow && !trigLevel_r;
  // free running restarts only on a fresh rise of the done flag, so
  // selecting code 0 while the flag already stands starts nothing
  wire doneRise  = doneFlag_r && !donePrev_r;
  wire freeEdge  = autoOn && trigSel == TRIG_FREE && doneRise;
  wire startNow  = convOn && autoOn && (trigEdge || freeEdge);

  wire locked    = lock_r == ST_LOCKED;
  wire accept    = smp.valid && !locked;
  wire dropped   = smp.valid && locked;

  always_comb begin
    lock_nxt = lock_r;
    case (lock_r)
      ST_UNLOCKED: if (rdLow) lock_nxt = ST_LOCKED;
      ST_LOCKED:   if (rdHigh) lock_nxt = ST_RELEASE;
      ST_RELEASE:  lock_nxt = rdLow ? ST_LOCKED : ST_UNLOCKED;
      default:     lock_nxt = ST_UNLOCKED;
    endcase
  end

  wire [7:0] irqEvents = {5'h00, dropped, startNow, accept};

  // read data mux, one cycle late
  wire [7:0] rdMux =
    (busReq.addr == OFS_RESLO)   ? resLowView  :
    (busReq.addr == OFS_RESHI)   ? resHighView :
    (busReq.addr == OFS_CTLB)    ? ctlB_r      :
    (busReq.addr == OFS_CTLA)    ? {ctlA_r[7:5], doneFlag_r, ctlA_r[3:0]} :
    (busReq.addr == OFS_PINDIS)  ? pinDis_r    :
    (busReq.addr == OFS_IRQSTAT) ? irqStat_r   :
    (busReq.addr == OFS_IRQMASK) ? irqMask_r   : RST_BYTE;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flagMeta_r <= '0;
      flagSync_r <= '0;
      pinMeta_r  <= '0;
      pinSync_r  <= '0;
    end else begin
      flagMeta_r <= trigFlags;
      flagSync_r <= flagMeta_r;
      pinMeta_r  <= pinLevel;
      pinSync_r  <= pinMeta_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctlB_r    <= RST_BYTE;
      ctlA_r    <= RST_BYTE;
      pinDis_r  <= RST_BYTE;
      irqMask_r <= RST_BYTE;
    end else begin
      if (wrCtlB) ctlB_r <= busReq.wdata;
      if (wrCtlA) ctlA_r <= {busReq.wdata[7:5], 1'b0, busReq.wdata[3:0]};
      if (wrPinDis) pinDis_r <= busReq.wdata;
      if (wrMask) irqMask_r <= busReq.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_r    <= RES_ZERO;
      lock_r      <= ST_UNLOCKED;
      doneFlag_r  <= 1'b0;
      trigLevel_r <= 1'b0;
      donePrev_r  <= 1'b0;
    end else begin
      lock_r <= lock_nxt;
      if (accept) result_r <= code_of(smp, bipolar);
      // a completion in the same cycle as the clear keeps the flag set
      if (accept) doneFlag_r <= 1'b1;
      else if (clrDone) doneFlag_r <= 1'b0;
      trigLevel_r <= trigNow;
      donePrev_r  <= doneFlag_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStat_r    <= RST_BYTE;
      irq          <= 1'b0;
      regRdata     <= RST_BYTE;
      convStart    <= 1'b0;
      pinBufferOff <= '0;
      portInput    <= '0;
    end else begin
      irqStat_r    <= (rdStat ? RST_BYTE : irqStat_r) | irqEvents;
      irq          <= |(((rdStat ? RST_BYTE : irqStat_r) | irqEvents)
                        & irqMask_r);
      regRdata     <= busReq.rd ? rdMux : RST_BYTE;
      convStart    <= startNow;
      pinBufferOff <= pinDis_r;
      portInput    <= pinSync_r & ~pinDis_r;
    end
  end

  sequence s_low_read;
    rdLow && lock_r == ST_UNLOCKED;
  endsequence

  sequence s_high_read;
    locked && rdHigh;
  endsequence

  chk_lock_holds: assert property (@(posedge clk) disable iff (!rst_n)
    (locked && sampleValid) |=>
      $stable(result_r))
    else $error("result changed while locked");
  chk_locked_drop: assert property (@(posedge clk) disable iff (!rst_n)
    (locked && sampleValid) |=> irqStat_r[IRQ_DROP])
    else $error("dropped sample not flagged");
  chk_result_load: assert property (@(posedge clk) disable iff (!rst_n)
    (accept && !sampleNegative && !bipolar) |=>
      result_r == $past(sampleMagnitude))
    else $error("result not loaded");
  chk_done_flag: assert property (@(posedge clk) disable iff (!rst_n)
    accept |=> doneFlag_r)
    else $error("done flag missed");
  chk_left_view: assert property (@(posedge clk) disable iff (!rst_n)
    leftAdj |-> resLowView[5:0] == 6'h00)
    else $error("left view low bits not zero");
  chk_right_view: assert property (@(posedge clk) disable iff (!rst_n)
    !leftAdj |-> resHighView[7:2] == 6'h00)
    else $error("right view high bits not zero");
  chk_unipolar_sat: assert property (@(posedge clk) disable iff (!rst_n)
    (accept && sampleNegative && !bipolar) |=> result_r == RES_SAT)
    else $error("unipolar negative not saturated");
  chk_no_manual_trig: assert property (@(posedge clk) disable iff (!rst_n)
    !autoOn |=> !convStart)
    else $error("start without auto trigger");
  chk_port_gated: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 ((portInput & pinBufferOff) == '0))
    else $error("disabled pin reads nonzero");
  chk_spare_bit: assert property (@(posedge clk) disable iff (!rst_n)
    wrCtlB |=> ctlB_r[CB_SPARE] == $past(regWdata[CB_SPARE]))
    else $error("spare bit not stored");

  chk_low_locks: assert property (
    @(posedge clk) disable iff (!rst_n) s_low_read |=> locked)
    else $error("low read did not lock");

  chk_high_unlocks: assert property (
    @(posedge clk) disable iff (!rst_n) s_high_read |=> lock_r == ST_RELEASE)
    else $error("high read did not release");

  chk_release_ends: assert property (
    @(posedge clk) disable iff (!rst_n)
    (lock_r == ST_RELEASE && !rdLow) |=> lock_r == ST_UNLOCKED)
    else $error("lock not cleared after release");

  chk_left_high: assert property (
    @(posedge clk) disable iff (!rst_n)
    leftAdj |-> resHighView == result_r[9:2])
    else $error("left view high byte wrong");

  chk_right_low: assert property (
    @(posedge clk) disable iff (!rst_n)
    !leftAdj |-> resLowView == result_r[7:0])
    else $error("right view low byte wrong");

  chk_read_view: assert property (
    @(posedge clk) disable iff (!rst_n)
    rdHigh |=> regRdata == $past(resHighView))
    else $error("high read not the current view");

  chk_bipolar_pos: assert property (
    @(posedge clk) disable iff (!rst_n)
    (accept && bipolar && !sampleNegative) |=>
      result_r == {1'b0, 9'($past(sampleMagnitude))})
    else $error("bipolar positive result wrong");

  chk_bipolar_neg: assert property (
    @(posedge clk) disable iff (!rst_n)
    (accept && bipolar && sampleNegative) |=>
      (result_r + {1'b0, 9'($past(sampleMagnitude))}) == RES_ZERO)
    else $error("bipolar negative result wrong");

  chk_done_clear: assert property (
    @(posedge clk) disable iff (!rst_n)
    (clrDone && !accept) |=> !doneFlag_r)
    else $error("done flag not cleared");

  chk_accept_event: assert property (
    @(posedge clk) disable iff (!rst_n)
    accept |=> irqStat_r[IRQ_DONE])
    else $error("completion not recorded");

  chk_start_edge: assert property (
    @(posedge clk) disable iff (!rst_n)
    (convOn && trigEdge) |=> convStart)
    else $error("trigger edge did not start");

  chk_free_no_trig: assert property (
    @(posedge clk) disable iff (!rst_n)
    (trigSel == TRIG_FREE && !doneRise) |=> !convStart)
    else $error("free running start without done rise");

  chk_off_no_start: assert property (
    @(posedge clk) disable iff (!rst_n)
    !convOn |=> !convStart)
    else $error("start while converter disabled");

  chk_trig_status: assert property (
    @(posedge clk) disable iff (!rst_n)
    convStart |-> irqStat_r[IRQ_TRIG])
    else $error("start not recorded in status");

  chk_sel_ignored: assert property (
    @(posedge clk) disable iff (!rst_n)
    !autoOn |=> !trigLevel_r)
    else $error("source tracked without auto trigger");

  chk_buf_copy: assert property (
    @(posedge clk) disable iff (!rst_n)
    1'b1 |=> pinBufferOff == $past(pinDis_r))
    else $error("buffer disable does not follow register");

  chk_port_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    1'b1 |=> (portInput & $past(pinDis_r)) == '0)
    else $error("disabled pin not reading zero");

  chk_pin_read: assert property (
    @(posedge clk) disable iff (!rst_n)
    (busReq.rd && busReq.addr == OFS_PINDIS) |=>
      regRdata == $past(pinDis_r))
    else $error("pin disable readback wrong");

  chk_spare_read: assert property (
    @(posedge clk) disable iff (!rst_n)
    (busReq.rd && busReq.addr == OFS_CTLB) |=>
      regRdata[CB_SPARE] == $past(ctlB_r[CB_SPARE]))
    else $error("spare bit readback wrong");

  chk_rdata_idle: assert property (
    @(posedge clk) disable iff (!rst_n)
    !busReq.rd |=> regRdata == RST_BYTE)
    else $error("read data not idle");

  chk_stat_clear: assert property (
    @(posedge clk) disable iff (!rst_n)
    (rdStat && irqEvents == 8'h00) |=> irqStat_r == RST_BYTE)
    else $error("status not cleared by read");

  chk_irq_mask: assert property (
    @(posedge clk) disable iff (!rst_n)
    (irqMask_r == RST_BYTE && !wrMask) |=> !irq)
    else $error("interrupt with all sources masked");
endmodule

// ### verif/arc_front_model.sv
// front-end model: finished samples, trigger flags and analog pin levels
// assumes its tasks are called right after a rising edge of clk
`timescale 1ns/1ps
module arc_front_model
  import arc_pkg::*;
(
  input  wire logic        clk,
  output logic             sampleValid,
  output logic             sampleNegative,
  output logic [RES_W-1:0] sampleMagnitude,
  output logic [7:1]       trigFlags,
  output logic [7:0]       pinLevel
);
  initial begin
    sampleValid = 1'b0;
    sampleNegative = 1'b0;
    sampleMagnitude = RES_ZERO;
    trigFlags = 7'h00;
    pinLevel = 8'hFF;
  end
  // magnitude lines are inverted after the strobe so stale values never match
  task automatic sample(input logic neg, input logic [9:0] mag);
    sampleValid <= 1'b1;
    sampleNegative <= neg;
    sampleMagnitude <= mag;
    @(posedge clk);
    sampleValid <= 1'b0;
    sampleMagnitude <= ~mag;
  endtask
  task automatic flag(input int i, input logic v);
    trigFlags[i] <= v;
  endtask
endmodule

// ### verif/arc_result_trigger_tb_top.sv
// self-checking bench for the result, control b, trigger and pin logic
// assumes the front-end model supplies samples, trigger flags and pins
`timescale 1ns/1ps
module arc_result_trigger_tb_top
  import arc_pkg::*;
;
  logic       clk, rst_n, regWr, regRd, convStart, irq, sV, sN;
  logic [7:0] regAddr, regWdata, regRdata, pinBufferOff, portInput, pinLv;
  logic [9:0] sM;
  logic [7:1] flags;
  int         n_errors, n_compared;

  arc_result_trigger DUT (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .sampleValid(sV), .sampleNegative(sN), .sampleMagnitude(sM),
    .trigFlags(flags), .pinLevel(pinLv), .pinBufferOff(pinBufferOff),
    .portInput(portInput), .convStart(convStart), .irq(irq));
  arc_front_model fe (.clk(clk), .sampleValid(sV), .sampleNegative(sN),
    .sampleMagnitude(sM), .trigFlags(flags), .pinLevel(pinLv));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic stop_test;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmpByte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmpBit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  // read data is looked at inside the one cycle where it stands
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 cmpByte(regRdata, exp);
    @(posedge clk);
  endtask
  task automatic waitStart(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (6) begin
      @(posedge clk);
      #1 seen = seen | convStart;
    end
    @(posedge clk);
    cmpBit(seen, exp);
  endtask
  task automatic tReset;
    rd(OFS_PINDIS, 8'h00);
    rd(OFS_CTLB, 8'h00);
    rd(8'h02, 8'h00);
    wr(OFS_RESLO, 8'hFF);
    rd(OFS_RESLO, 8'h00);
    rd(OFS_RESHI, 8'h00);
  endtask
  task automatic tJustify;
    fe.sample(1'b0, 10'h2A5);
    rd(OFS_RESLO, 8'hA5);
    rd(OFS_RESHI, 8'h02);
    wr(OFS_CTLB, 8'h18);
    rd(OFS_CTLB, 8'h18);
    rd(OFS_RESHI, 8'hA9);
    rd(OFS_RESLO, 8'h40);
    rd(OFS_RESHI, 8'hA9);
    wr(OFS_CTLB, 8'h08);
  endtask
  task automatic tLock;
    rd(OFS_RESLO, 8'hA5);
    fe.sample(1'b0, 10'h155);
    rd(OFS_RESHI, 8'h02);
    rd(OFS_RESLO, 8'hA5);
    rd(OFS_RESHI, 8'h02);
    fe.sample(1'b0, 10'h155);
    rd(OFS_RESLO, 8'h55);
    rd(OFS_RESHI, 8'h01);
  endtask
  task automatic tPolar;
    fe.sample(1'b1, 10'h005);
    rd(OFS_RESLO, 8'hFF);
    rd(OFS_RESHI, 8'h03);
    wr(OFS_CTLB, 8'h80);
    fe.sample(1'b1, 10'h005);
    rd(OFS_RESLO, 8'hFB);
    rd(OFS_RESHI, 8'h03);
  endtask
  task automatic tTrig;
    wr(OFS_CTLA, 8'h02);
    wr(OFS_CTLB, 8'h01);
    fe.flag(1, 1'b1);
    waitStart(1'b0);
    fe.flag(1, 1'b0);
    repeat (4) @(posedge clk);
    wr(OFS_CTLA, 8'h03);
    for (int c = 1; c < 8; c++) begin
      wr(OFS_CTLB, 8'(c));
      fe.flag(c, 1'b1);
      waitStart(1'b1);
      fe.flag(c, 1'b0);
    end
    wr(OFS_CTLB, 8'h01);
    fe.flag(2, 1'b1);
    repeat (4) @(posedge clk);
    wr(OFS_CTLB, 8'h02);
    waitStart(1'b1);
    fe.flag(2, 1'b0);
    repeat (4) @(posedge clk);
    wr(OFS_CTLB, 8'h00);
    waitStart(1'b0);
    rd(OFS_CTLA, 8'h13);
    wr(OFS_CTLA, 8'h13);
    rd(OFS_CTLA, 8'h03);
  endtask
  task automatic tPins;
    wr(OFS_PINDIS, 8'h0F);
    repeat (5) @(posedge clk);
    #1 cmpByte(portInput, 8'hF0);
    cmpByte(pinBufferOff, 8'h0F);
    @(posedge clk);
    rd(OFS_PINDIS, 8'h0F);
  endtask
  // done was cleared at the end of tTrig, so this sample is a fresh rise
  task automatic tIrq;
    rd(OFS_IRQSTAT, 8'h07);
    #1 cmpBit(irq, 1'b0);
    @(posedge clk);
    wr(OFS_IRQMASK, 8'h01);
    fe.sample(1'b0, 10'h001);
    repeat (2) @(posedge clk);
    #1 cmpBit(irq, 1'b1);
    @(posedge clk);
    rd(OFS_IRQSTAT, 8'h03);
    repeat (2) @(posedge clk);
    #1 cmpBit(irq, 1'b0);
    @(posedge clk);
    wr(OFS_IRQMASK, 8'h00);
    fe.sample(1'b0, 10'h001);
    repeat (3) @(posedge clk);
    #1 cmpBit(irq, 1'b0);
    @(posedge clk);
  endtask

  initial begin
    rst_n = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    n_errors = 0;
    n_compared = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    tReset();
    tJustify();
    tLock();
    tPolar();
    tTrig();
    tPins();
    tIrq();
    stop_test();
  end
  // the sequence needs well under 1000 cycles
  initial begin
    #20000;
    n_errors++;
    stop_test();
  end
endmodule
